// ==== hw/light_cfg_bank.sv ====
// Functional notes
// [R01] Interrupt pin: code 00 gives combined interrupt, 01 gives hysteresis state.
// [R02] Sync pin: code 00 gives general-purpose output, 01 gives hysteresis state.
// [R03] Host never writes codes 10 or 11 to either pin select field.
// [R04] Per-step enable runs calibration every nth step iteration, not per round.
// [R05] Host keeps per-step calibration cleared while automatic gain control runs.
// [R06] Gain target is half of maximum with bit 0, quarter with bit 1.
// [R07] Sequencer interrupt per step when bit set, else once per full round.
// [R08] Power-on rising edge clears oscillator trim unless keep bit is set.
// [R09] Keep bit holds oscillator trim unchanged across power-on.
// [R10] Format 00 writes 16-bit words; analog FFFF, digital FFFE.
// [R11] Format 01 writes 24-bit words; analog FFFFFF, digital FFFFE.
// [R12] Format 11 writes 32-bit words, analog all ones; 10 is reserved.
// [R13] Direct mode puts light interrupt state on pins selecting hysteresis.
// [R14] Writable fields reset to zero; reserved bits read as zero.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "light_cfg_consts.svh"

module light_cfg_bank (
   input  wire logic                        core_clk_i,
   input  wire logic                        sys_rst_i,
   input  wire logic [7:0]                  reg_addr_i,
   input  wire logic [7:0]                  reg_wdata_i,
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   output      logic [7:0]                  reg_rdata_o,
   input  wire logic                        combined_irq_i,
   input  wire logic                        light_threshold_hysteresis_state_i,
   input  wire logic                        sync_gpio_out_i,
   input  wire logic                        light_irq_direct_mode_i,
   input  wire logic                        light_irq_state_i,
   output      logic                        irq_pin_o,
   output      logic                        sync_pin_o,
   input  wire logic                        seq_step_done_i,
   input  wire logic                        seq_round_done_i,
   output      logic                        mod_calibrate_o,
   output      logic                        sequencer_system_irq_o,
   input  wire logic [31:0]                 meas_max_i,
   output      logic [31:0]                 agc_target_o,
   input  wire logic                        power_on_bit_i,
   input  wire logic                        trim_load_i,
   input  wire logic [7:0]                  trim_value_i,
   output      logic [7:0]                  oscillator_trim_value_o,
   input  wire light_cfg_pkg::light_sample_t sample_i,
   output      light_cfg_pkg::fifo_word_t    fifo_word_o,
   output      logic                        irq_o
);
   import light_cfg_pkg::*;

   pin_routing_t pin_cfg_r;
   seq_format_t  seq_cfg_r;
   logic [7:0]   irq_status_r;
   logic [7:0]   irq_status_nxt;
   logic [7:0]   irq_mask_r;
   logic [7:0]   evt;
   logic [3:0]   iter_cnt_r;
   logic         pon_r;
   logic         pon_rise;
   logic [7:0]   rdata_nxt;
   logic         cal_evt;
   logic         sint_evt;
   logic         trim_clr;
   logic         sat_evt;
   logic         pin_hyst_level;

   // Register writes.
   // [R14] reset to zero
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_cfg_r  <= pin_routing_t'(`CFG_RESET);
         seq_cfg_r  <= seq_format_t'(`CFG_RESET);
         irq_mask_r <= `CFG_RESET;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `REG_PIN_ROUTING:
               pin_cfg_r <= pin_routing_t'(reg_wdata_i & `PIN_ROUTING_WMASK);
            `REG_SEQ_FORMAT:
               seq_cfg_r <= seq_format_t'(reg_wdata_i & `SEQ_FORMAT_WMASK);
            `REG_IRQ_MASK:
               irq_mask_r <= reg_wdata_i & `IRQ_EVT_WMASK;
            default:
               irq_mask_r <= irq_mask_r;
         endcase
      end
   end

   // Reads answer in the next cycle only; unmapped addresses read zero.
   // [R14] reserved bits read zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `REG_PIN_ROUTING: rdata_nxt = pin_cfg_r & `PIN_ROUTING_WMASK;
            `REG_SEQ_FORMAT:  rdata_nxt = seq_cfg_r & `SEQ_FORMAT_WMASK;
            `REG_IRQ_STATUS:  rdata_nxt = irq_status_r;
            `REG_IRQ_MASK:    rdata_nxt = irq_mask_r;
            default:          rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= 8'h00;
      else
         reg_rdata_o <= rdata_nxt;
   end

   // Pin routing. In direct mode the pin shows the live interrupt state of
   // the light channel instead of the filtered hysteresis level.
   // [R13] direct mode source
   assign pin_hyst_level = light_irq_direct_mode_i ? light_irq_state_i
                                                   : light_threshold_hysteresis_state_i;

   // [R01] interrupt pin mux
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         irq_pin_o <= 1'b0;
      else if (pin_cfg_r.irq_pin_select == `SEL_HYST)
         irq_pin_o <= pin_hyst_level;
      else
         irq_pin_o <= combined_irq_i;
   end

   // Reserved codes fall back to the default source; the host must not use them.
   // [R02] sync pin mux
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         sync_pin_o <= 1'b0;
      else if (pin_cfg_r.sync_pin_select == `SEL_HYST)
         sync_pin_o <= pin_hyst_level;
      else
         sync_pin_o <= sync_gpio_out_i;
   end

   // Calibration scheduling.
   // [R04] nth step calibration
   assign cal_evt = seq_cfg_r.cal_per_step
                  ? (seq_step_done_i && iter_cnt_r == `CAL_NTH - 4'h1)
                  : seq_round_done_i;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         iter_cnt_r <= 4'h0;
      else if (!seq_cfg_r.cal_per_step || cal_evt)
         iter_cnt_r <= 4'h0;
      else if (seq_step_done_i)
         iter_cnt_r <= iter_cnt_r + 4'h1;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         mod_calibrate_o <= 1'b0;
      else
         mod_calibrate_o <= cal_evt;
   end

   // [R07] system interrupt cadence
   assign sint_evt = seq_cfg_r.sint_per_step ? seq_step_done_i : seq_round_done_i;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         sequencer_system_irq_o <= 1'b0;
      else
         sequencer_system_irq_o <= sint_evt;
   end

   // [R06] gain target level
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         agc_target_o <= 32'h00000000;
      else if (seq_cfg_r.agc_quarter_target)
         agc_target_o <= meas_max_i >> 2;
      else
         agc_target_o <= meas_max_i >> 1;
   end

   // The power-on clear beats a same-cycle load, so with the keep bit clear a stale trim never survives power-on.
   assign pon_rise = power_on_bit_i && !pon_r;
   // [R08] clear on power-on
   assign trim_clr = pon_rise && !seq_cfg_r.keep_oscillator_trim;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         pon_r <= 1'b0;
      else
         pon_r <= power_on_bit_i;
   end

   // [R09] keep trim value
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         oscillator_trim_value_o <= 8'h00;
      else if (trim_clr)
         oscillator_trim_value_o <= 8'h00;
      else if (trim_load_i)
         oscillator_trim_value_o <= trim_value_i;
   end

   // Light word formatting. Values wider than the word keep their low bits.
   assign sat_evt = sample_i.valid && (sample_i.analog_sat || sample_i.digital_sat)
                 && seq_cfg_r.light_fifo_word_format != 2'h2;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         fifo_word_o <= '0;
      else
      begin
         fifo_word_o.valid <= 1'b0;
         if (sample_i.valid)
         begin
            case (seq_cfg_r.light_fifo_word_format)
               // [R10] 16-bit words
               `FMT_16:
               begin
                  fifo_word_o.valid <= 1'b1;
                  fifo_word_o.bytes <= `BYTES_16;
                  if (sample_i.analog_sat)
                     fifo_word_o.data <= `SAT16_ANALOG;
                  else if (sample_i.digital_sat)
                     fifo_word_o.data <= `SAT16_DIGITAL;
                  else
                     fifo_word_o.data <= {16'h0000, sample_i.value[15:0]};
               end
               // [R11] 24-bit words
               `FMT_24:
               begin
                  fifo_word_o.valid <= 1'b1;
                  fifo_word_o.bytes <= `BYTES_24;
                  if (sample_i.analog_sat)
                     fifo_word_o.data <= `SAT24_ANALOG;
                  else if (sample_i.digital_sat)
                     fifo_word_o.data <= `SAT24_DIGITAL;
                  else
                     fifo_word_o.data <= {8'h00, sample_i.value[23:0]};
               end
               // [R12] 32-bit words
               `FMT_32:
               begin
                  fifo_word_o.valid <= 1'b1;
                  fifo_word_o.bytes <= `BYTES_32;
                  if (sample_i.analog_sat)
                     fifo_word_o.data <= `SAT32_ANALOG;
                  else
                     fifo_word_o.data <= sample_i.value;
               end
               // The reserved code writes nothing rather than guess a width.
               default:
                  fifo_word_o.valid <= 1'b0;
            endcase
         end
      end
   end

   // Interrupt status: a set in the same cycle as a clearing read wins.
   always_comb
   begin
      evt = 8'h00;
      evt[`EVT_SEQ]  = sint_evt;
      evt[`EVT_CAL]  = cal_evt;
      evt[`EVT_TRIM] = trim_clr;
      evt[`EVT_SAT]  = sat_evt;
      irq_status_nxt = irq_status_r;
      if (reg_rd_i && reg_addr_i == `REG_IRQ_STATUS)
         irq_status_nxt = 8'h00;
      irq_status_nxt = irq_status_nxt | evt;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         irq_status_r <= 8'h00;
      else
         irq_status_r <= irq_status_nxt;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_status_nxt & irq_mask_r);
   end

   chk_irq_pin_route: assert property ( // [R01]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      pin_cfg_r.irq_pin_select == `SEL_DEFAULT |=> irq_pin_o == $past(combined_irq_i))
      else $error("Interrupt pin does not follow the combined interrupt.");
   chk_sync_pin_route: assert property ( // [R02]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      pin_cfg_r.sync_pin_select == `SEL_HYST && !light_irq_direct_mode_i
      |=> sync_pin_o == $past(light_threshold_hysteresis_state_i))
      else $error("Sync pin does not follow the hysteresis state.");
   chk_direct_pin_state: assert property ( // [R13]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      pin_cfg_r.irq_pin_select == `SEL_HYST && light_irq_direct_mode_i
      |=> irq_pin_o == $past(light_irq_state_i))
      else $error("Direct mode does not show the light interrupt state.");
   chk_cal_per_round: assert property ( // [R04]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !seq_cfg_r.cal_per_step && seq_step_done_i && !seq_round_done_i
      |=> !mod_calibrate_o)
      else $error("Calibration started on a step while per-step is off.");
   chk_cal_nth_step: assert property ( // [R04]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      mod_calibrate_o && seq_cfg_r.cal_per_step && $past(seq_cfg_r.cal_per_step)
      |-> $past(seq_step_done_i) && $past(iter_cnt_r) == `CAL_NTH - 4'h1)
      else $error("Per-step calibration not on the nth iteration.");
   chk_agc_target: assert property ( // [R06]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      ##1 agc_target_o == ($past(seq_cfg_r.agc_quarter_target)
         ? $past(meas_max_i) >> 2 : $past(meas_max_i) >> 1))
      else $error("Gain target is not the selected fraction of maximum.");
   chk_sint_cadence: assert property ( // [R07]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      sequencer_system_irq_o |-> ($past(seq_cfg_r.sint_per_step)
         ? $past(seq_step_done_i) : $past(seq_round_done_i)))
      else $error("Sequencer interrupt at the wrong cadence.");
   chk_trim_clear: assert property ( // [R08]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(power_on_bit_i) && !seq_cfg_r.keep_oscillator_trim
      |=> oscillator_trim_value_o == 8'h00)
      else $error("Oscillator trim not cleared at power-on.");
   chk_trim_kept: assert property ( // [R09]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(power_on_bit_i) && seq_cfg_r.keep_oscillator_trim && !trim_load_i
      |=> $stable(oscillator_trim_value_o))
      else $error("Oscillator trim changed although keep is set.");
   chk_fmt16_sat: assert property ( // [R10]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      sample_i.valid && seq_cfg_r.light_fifo_word_format == `FMT_16
      |=> fifo_word_o.valid && fifo_word_o.bytes == `BYTES_16
         && (!$past(sample_i.analog_sat) || fifo_word_o.data == `SAT16_ANALOG)
         && ($past(sample_i.analog_sat) || !$past(sample_i.digital_sat)
            || fifo_word_o.data == `SAT16_DIGITAL))
      else $error("16-bit word or saturation code wrong.");
   chk_fmt24_sat: assert property ( // [R11]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      sample_i.valid && sample_i.digital_sat && !sample_i.analog_sat
      && seq_cfg_r.light_fifo_word_format == `FMT_24
      |=> fifo_word_o.data == `SAT24_DIGITAL && fifo_word_o.bytes == `BYTES_24)
      else $error("24-bit digital saturation code wrong.");
   chk_fmt_reserved: assert property ( // [R12]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      seq_cfg_r.light_fifo_word_format == 2'h2 |=> !fifo_word_o.valid)
      else $error("Reserved format wrote a light word.");
   chk_reserved_zero: assert property ( // [R14]
      @(posedge core_clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == `REG_SEQ_FORMAT
      |=> (reg_rdata_o & ~`SEQ_FORMAT_WMASK) == 8'h00)
      else $error("Reserved bits read non-zero.");
endmodule : light_cfg_bank

// ==== hw/light_cfg_consts.svh ====
`ifndef LIGHT_CFG_CONSTS_SVH
`define LIGHT_CFG_CONSTS_SVH

// Register offsets.
`define REG_PIN_ROUTING    8'hA4
`define REG_SEQ_FORMAT     8'hA5
`define REG_IRQ_STATUS     8'hB0
`define REG_IRQ_MASK       8'hB1

// Writable bits of each register and their common reset value.
`define PIN_ROUTING_WMASK  8'h33
`define SEQ_FORMAT_WMASK   8'h7B
`define IRQ_EVT_WMASK      8'h0F
`define CFG_RESET          8'h00

// Field positions.
`define IRQ_SEL_LSB        4
`define SYNC_SEL_LSB       0
`define CAL_STEP_BIT       6
`define AGC_TARGET_BIT     5
`define SINT_STEP_BIT      4
`define KEEP_TRIM_BIT      3
`define FIFO_FMT_LSB       0

// Pin routing selections.
`define SEL_DEFAULT        2'h0
`define SEL_HYST           2'h1

// Light word formats.
`define FMT_16             2'h0
`define FMT_24             2'h1
`define FMT_32             2'h3

// Saturation codes.
`define SAT16_ANALOG       32'h0000FFFF
`define SAT16_DIGITAL      32'h0000FFFE
`define SAT24_ANALOG       32'h00FFFFFF
`define SAT24_DIGITAL      32'h000FFFFE
`define SAT32_ANALOG       32'hFFFFFFFF

// Word sizes in bytes.
`define BYTES_16           3'h2
`define BYTES_24           3'h3
`define BYTES_32           3'h4

// Sequencer step iterations between two calibrations.
`define CAL_NTH            4'h4

// Interrupt status bit positions.
`define EVT_SEQ            0
`define EVT_CAL            1
`define EVT_TRIM           2
`define EVT_SAT            3

`endif

// ==== hw/light_cfg_pkg.sv ====
package light_cfg_pkg;

   typedef struct packed {
      logic [1:0] rsv_hi;
      logic [1:0] irq_pin_select;
      logic [1:0] rsv_mid;
      logic [1:0] sync_pin_select;
   } pin_routing_t;

   typedef struct packed {
      logic       rsv7;
      logic       cal_per_step;
      logic       agc_quarter_target;
      logic       sint_per_step;
      logic       keep_oscillator_trim;
      logic       rsv2;
      logic [1:0] light_fifo_word_format;
   } seq_format_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] value;
      logic        analog_sat;
      logic        digital_sat;
   } light_sample_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  bytes;
      logic [31:0] data;
   } fifo_word_t;

endpackage : light_cfg_pkg

// ==== sim/light_host_model.sv ====
`timescale 1ns/1ps
module light_host_model (
   input  wire logic       core_clk_i,
   output      logic [7:0] reg_addr_o,
   output      logic [7:0] reg_wdata_o,
   output      logic       reg_wr_o,
   output      logic       reg_rd_o
);
   initial
   begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'h0;
      reg_rd_o = 1'h0;
   end

   // Callers pass only pin select codes 00 and 01.
   // No caller enables automatic gain control, so per-step calibration may be set.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'h1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'h0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'h1;
      @(posedge core_clk_i);
      reg_rd_o <= 1'h0;
      reg_addr_o <= ~a;
   endtask : rd
endmodule : light_host_model

// ==== sim/light_cfg_bank_test.sv ====
`timescale 1ns/1ps
module light_cfg_bank_test;
   import light_cfg_pkg::*;
   logic          clk = 1'h0;
   logic          rst, wr, rd, comb, hyst, gpio, direct, lstate, irq_pin, sync_pin;
   logic          step, round, cal, sint, power_on_bit, trim_ld, irq, rd_d;
   logic [7:0]    addr, wdata, rdata, trim_val, trim_o;
   logic [31:0]   mmax, target, v, e;
   logic [2:0]    by;
   light_sample_t smp;
   fifo_word_t    fw;
   integer        seed = 32'hEA51EDF9;
   int            n_mismatch = 0, checked = 0, cyc = 0, n_cal = 0, n_sint = 0, c0, s0;
   logic [7:0]    rd_q[$];
   logic [34:0]   fw_q[$];

   always #5 clk = ~clk;

   light_host_model host (.core_clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_wr_o(wr), .reg_rd_o(rd));

   light_cfg_bank dut (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .combined_irq_i(comb), .light_threshold_hysteresis_state_i(hyst),
      .sync_gpio_out_i(gpio), .light_irq_direct_mode_i(direct),
      .light_irq_state_i(lstate), .irq_pin_o(irq_pin), .sync_pin_o(sync_pin),
      .seq_step_done_i(step), .seq_round_done_i(round), .mod_calibrate_o(cal),
      .sequencer_system_irq_o(sint), .meas_max_i(mmax), .agc_target_o(target),
      .power_on_bit_i(power_on_bit), .trim_load_i(trim_ld), .trim_value_i(trim_val),
      .oscillator_trim_value_o(trim_o), .sample_i(smp), .fifo_word_o(fw), .irq_o(irq));

   task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
      rd_q.push_back(x);
      host.rd(a);
   endtask : rd_exp

   task automatic seqp(input logic st, input logic rn);
      @(posedge clk);
      step <= st;
      round <= rn;
      @(posedge clk);
      step <= 1'h0;
      round <= 1'h0;
   endtask : seqp

   // Read data stands only in the cycle after the strobe, so it is taken there.
   always @(posedge clk)
   begin
      rd_d <= rd;
      if (rd_d)
         chk("rdata", rdata, rd_q.pop_front());
      if (fw.valid === 1'h1)
         chk("fifo", {fw.bytes, fw.data}, fw_q.size() > 0 ? fw_q.pop_front() : 'x);
      if (cal === 1'h1)
         n_cal++;
      if (sint === 1'h1)
         n_sint++;
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   initial
   begin
      rst = 1'h1;
      {comb, hyst, gpio, direct, lstate, step, round, power_on_bit, trim_ld} = 9'h000;
      mmax = 32'h0;
      trim_val = 8'h00;
      smp = '0;
      rd_d = 1'h0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      rd_exp(8'hA4, 8'h00);
      rd_exp(8'hA5, 8'h00);
      host.wr(8'hA4, 8'hCD);
      rd_exp(8'hA4, 8'h01);
      host.wr(8'hA5, 8'hA4);
      rd_exp(8'hA5, 8'h20);
      rd_exp(8'h3C, 8'h00);
      host.wr(8'hA5, 8'h00);
      host.wr(8'hB1, 8'h00);
      seqp(1'h0, 1'h1);
      repeat (2) @(posedge clk);
      #1;
      chk("irq masked", irq, 1'h0);
      host.wr(8'hB1, 8'h01);
      @(posedge clk);
      #1;
      chk("irq", irq, 1'h1);
      rd_exp(8'hB0, 8'h03);
      repeat (2) @(posedge clk);
      #1;
      chk("irq cleared", irq, 1'h0);
      for (int i = 0; i < 8; i++)
      begin
         if (i % 4 == 0)
            host.wr(8'hA4, i[2] ? 8'h11 : 8'h00);
         @(posedge clk);
         {comb, hyst, gpio, lstate} <= 4'($random(seed));
         direct <= i[0];
         repeat (2) @(posedge clk);
         #1;
         chk("irq_pin", irq_pin, i[2] ? (direct ? lstate : hyst) : comb);
         chk("sync_pin", sync_pin, i[2] ? (direct ? lstate : hyst) : gpio);
      end
      for (int i = 0; i < 2; i++)
      begin
         host.wr(8'hA5, i ? 8'h20 : 8'h00);
         mmax <= $random(seed);
         repeat (2) @(posedge clk);
         #1;
         chk("agc", target, i ? mmax >> 2 : mmax >> 1);
      end
      // Eight steps then a round tell per-step and per-round counting apart.
      for (int i = 0; i < 4; i++)
      begin
         host.wr(8'hA5, {1'h0, i[1], 1'h0, i[0], 4'h0});
         c0 = n_cal;
         s0 = n_sint;
         repeat (8) seqp(1'h1, 1'h0);
         seqp(1'h0, 1'h1);
         repeat (3) @(posedge clk);
         chk("sint", 32'(n_sint - s0), i[0] ? 32'h8 : 32'h1);
         chk("cal", 32'(n_cal - c0), i[1] ? 32'h2 : 32'h1);
      end
      for (int i = 0; i < 2; i++)
      begin
         host.wr(8'hA5, i ? 8'h00 : 8'h08);
         @(posedge clk);
         trim_val <= 8'($random(seed)) | 8'h01;
         trim_ld <= 1'h1;
         power_on_bit <= 1'h0;
         @(posedge clk);
         trim_ld <= 1'h0;
         power_on_bit <= 1'h1;
         repeat (2) @(posedge clk);
         #1;
         chk("trim", trim_o, i ? 8'h00 : trim_val);
      end
      for (int f = 0; f < 4; f++)
      begin
         host.wr(8'hA5, 8'(f));
         for (int k = 0; k < 4; k++)
         begin
            v = $random(seed);
            by = f == 0 ? 3'h2 : f == 1 ? 3'h3 : 3'h4;
            e = f == 0 ? {16'h0, v[15:0]} : f == 1 ? {8'h0, v[23:0]} : v;
            if (k[1] && f != 3)
               e = f == 0 ? 32'h0000FFFE : 32'h000FFFFE;
            if (k[0])
               e = f == 0 ? 32'h0000FFFF : f == 1 ? 32'h00FFFFFF : 32'hFFFFFFFF;
            if (f != 2)
               fw_q.push_back({by, e});
            @(posedge clk);
            smp <= {1'h1, v, k[0], k[1]};
            @(posedge clk);
            smp.valid <= 1'h0;
         end
      end
      repeat (3) @(posedge clk);
      #1;
      chk("fifo drained", 32'(fw_q.size()), 32'h0);
      chk("irq pending", irq, 1'h1);
      rd_exp(8'hB0, 8'h0F);
      rd_exp(8'hB0, 8'h00);
      repeat (3) @(posedge clk);
      end_sim();
   end
endmodule : light_cfg_bank_test
